// ### hdl/fic_pkg.sv
package fic_pkg;
	localparam int NUM_SRC = 7;
	localparam int NUM_LVL = 4;
	localparam int CALL_CYCLES = 2;
	// ======================================================
	// register map
	localparam logic [7:0] OFS_ENABLE = 8'h00;
	localparam logic [7:0] OFS_PRIO_LOW = 8'h04;
	localparam logic [7:0] OFS_PRIO_HIGH = 8'h08;
	localparam logic [7:0] OFS_CONTROL = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] RST_ENABLE = 8'h00;
	localparam logic [6:0] RST_PRIO = 7'h00;
	localparam logic [1:0] RST_CONTROL = 2'h0;
	localparam int BIT_GLOBAL = 7;
	localparam int BIT_EDGE0 = 0;
	localparam int BIT_EDGE1 = 1;
	// ======================================================
	// sources in polling order
	localparam logic [2:0] SRC_EXT0 = 3'h0;
	localparam logic [2:0] SRC_TMR0 = 3'h1;
	localparam logic [2:0] SRC_EXT1 = 3'h2;
	localparam logic [2:0] SRC_TMR1 = 3'h3;
	localparam logic [2:0] SRC_CAPT = 3'h4;
	localparam logic [2:0] SRC_SER = 3'h5;
	localparam logic [2:0] SRC_TMR2 = 3'h6;
	typedef enum logic [1:0] {
		CALL_IDLE = 2'h0,
		CALL_PUSH = 2'h1,
		CALL_LOAD = 2'h3
	} fic_call_e;
	// register bit that holds a source's enable or priority
	function automatic int fic_reg_bit(input int src);
		case (src)
			4: fic_reg_bit = 6;
			5: fic_reg_bit = 4;
			6: fic_reg_bit = 5;
			default: fic_reg_bit = src;
		endcase
	endfunction : fic_reg_bit
	function automatic logic [15:0] fic_vector(input logic [2:0] src);
		case (src)
			SRC_EXT0: fic_vector = 16'h0003;
			SRC_TMR0: fic_vector = 16'h000B;
			SRC_EXT1: fic_vector = 16'h0013;
			SRC_TMR1: fic_vector = 16'h001B;
			SRC_CAPT: fic_vector = 16'h0033;
			SRC_SER: fic_vector = 16'h0023;
			default: fic_vector = 16'h002B;
		endcase
	endfunction : fic_vector
	// index of highest set marker, valid flag on top
	function automatic logic [2:0] fic_top_level(input logic [3:0] marks);
		fic_top_level = 3'h0;
		for (int i = 0; i < NUM_LVL; i++) begin
			if (marks[i]) begin
				fic_top_level = {1'b1, 2'(i)};
			end
		end
	endfunction : fic_top_level
endpackage : fic_pkg

// ### hdl/fic_ext_flag.sv
`timescale 1ns/1ps
`default_nettype none
module fic_ext_flag (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic pinN,
	input wire logic edgeMode,
	input wire logic sample,
	input wire logic clear,
	output logic flag
);
	typedef struct packed {
		logic lastHigh;
		logic flag;
	} fic_ext_s;
	fic_ext_s cur;
	fic_ext_s next_cur;
	always_comb begin
		next_cur = cur;
		if (clear && edgeMode) begin
			next_cur.flag = 1'b0;
		end
		if (sample) begin
			next_cur.lastHigh = pinN;
			if (edgeMode) begin
				// set wins over a vector clear in the same cycle
				if (cur.lastHigh && !pinN) begin
					next_cur.flag = 1'b1;
				end
			end else begin
				next_cur.flag = !pinN;
			end
		end
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cur <= '{lastHigh: 1'b1, flag: 1'b0};
		end else begin
			cur <= next_cur;
		end
	end
	assign flag = cur.flag;
endmodule : fic_ext_flag
`default_nettype wire

// ### hdl/fic_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module fic_arbiter (
	input wire logic [fic_pkg::NUM_SRC-1:0] request,
	input wire logic [fic_pkg::NUM_SRC-1:0] prioHigh,
	input wire logic [fic_pkg::NUM_SRC-1:0] prioLow,
	input wire logic [fic_pkg::NUM_LVL-1:0] inProgress,
	output logic grantValid,
	output logic [2:0] grantSrc,
	output logic [1:0] grantLevel
);
	import fic_pkg::*;
	logic [2:0] top;
	logic [1:0] lvl;
	logic found;
	always_comb begin
		top = fic_top_level(inProgress);
		found = 1'b0;
		grantSrc = 3'h0;
		grantLevel = 2'h0;
		lvl = 2'h0;
		for (int i = 0; i < NUM_SRC; i++) begin
			lvl = {prioHigh[i], prioLow[i]};
			// strict compare keeps the earlier source on a tie
			if (request[i] && (!found || lvl > grantLevel)) begin
				found = 1'b1;
				grantSrc = 3'(i);
				grantLevel = lvl;
			end
		end
		// only a strictly higher level may preempt
		grantValid = found && (!top[2] || grantLevel > top[1:0]);
	end
endmodule : fic_arbiter
`default_nettype wire

// ### hdl/fic_top.sv
`timescale 1ns/1ps
`default_nettype none
module fic_top #(
	parameter int ADDR_W = 8
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic ext_request_0_n,
	input wire logic ext_request_1_n,
	input wire logic state5Phase2,
	input wire logic state2Phase2,
	input wire logic cycleEnd,
	input wire logic lastCycle,
	input wire logic retiOrRegWrite,
	input wire logic returnFromInterrupt,
	input wire logic timer0OverflowFlag,
	input wire logic timer1OverflowFlag,
	input wire logic timer2OverflowFlag,
	input wire logic timer2ExternalFlag,
	input wire logic serialRxFlag,
	input wire logic serialTxFlag,
	input wire logic captureArrayFlag,
	output logic callActive,
	output logic pushPc,
	output logic loadPc,
	output logic [15:0] vectorAddress,
	output logic clearTimer0Overflow,
	output logic clearTimer1Overflow,
	output logic popTwoBytes
);
	import fic_pkg::*;
	typedef struct packed {
		logic [7:0] enable;
		logic [6:0] prioLow;
		logic [6:0] prioHigh;
		logic [1:0] edgeMode;
		logic [NUM_LVL-1:0] inProgress;
		logic [NUM_SRC-1:0] samples;
		logic [NUM_SRC-1:0] polled;
		logic holdOff;
		fic_call_e call;
		logic [15:0] vector;
		logic pushPc;
		logic loadPc;
		logic clr0;
		logic clr1;
		logic clrExt0;
		logic clrExt1;
		logic pop;
		logic [31:0] rdata;
	} fic_state_s;
	fic_state_s cur;
	fic_state_s next_cur;
	logic ext0Flag;
	logic ext1Flag;
	logic [NUM_SRC-1:0] liveFlags;
	logic [NUM_SRC-1:0] request;
	logic [NUM_SRC-1:0] srcHigh;
	logic [NUM_SRC-1:0] srcLow;
	logic grantValid;
	logic [2:0] grantSrc;
	logic [1:0] grantLevel;
	logic setupPhase;
	logic accessPhase;
	logic mapped;
	logic regWrite;
	logic endInstr;
	logic blockPoll;
	logic [2:0] topMark;
	// ======================================================
	// flag capture
	fic_ext_flag u_ext0 (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.pinN(ext_request_0_n),
		.edgeMode(cur.edgeMode[BIT_EDGE0]),
		.sample(state5Phase2),
		.clear(cur.clrExt0),
		.flag(ext0Flag)
	);
	fic_ext_flag u_ext1 (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.pinN(ext_request_1_n),
		.edgeMode(cur.edgeMode[BIT_EDGE1]),
		.sample(state5Phase2),
		.clear(cur.clrExt1),
		.flag(ext1Flag)
	);
	always_comb begin
		liveFlags = '0;
		liveFlags[SRC_TMR0] = timer0OverflowFlag;
		liveFlags[SRC_TMR1] = timer1OverflowFlag;
		liveFlags[SRC_CAPT] = captureArrayFlag;
		liveFlags[SRC_SER] = serialRxFlag | serialTxFlag;
		liveFlags[SRC_TMR2] = timer2OverflowFlag | timer2ExternalFlag;
		for (int i = 0; i < NUM_SRC; i++) begin
			// polled copy, so a late request other than timer2 overflow never skips its wait cycle
			request[i] = cur.polled[i] && cur.enable[fic_reg_bit(i)]
				&& cur.enable[BIT_GLOBAL];
			srcHigh[i] = cur.prioHigh[fic_reg_bit(i)];
			srcLow[i] = cur.prioLow[fic_reg_bit(i)];
		end
	end
	fic_arbiter u_arb (
		.request(request),
		.prioHigh(srcHigh),
		.prioLow(srcLow),
		.inProgress(cur.inProgress),
		.grantValid(grantValid),
		.grantSrc(grantSrc),
		.grantLevel(grantLevel)
	);
	// ======================================================
	// bus decode
	always_comb begin
		setupPhase = psel && !penable;
		accessPhase = psel && penable;
		mapped = paddr == ADDR_W'(OFS_ENABLE) || paddr == ADDR_W'(OFS_PRIO_LOW)
			|| paddr == ADDR_W'(OFS_PRIO_HIGH) || paddr == ADDR_W'(OFS_CONTROL)
			|| paddr == ADDR_W'(OFS_STATUS);
		regWrite = accessPhase && pwrite && (paddr == ADDR_W'(OFS_ENABLE)
			|| paddr == ADDR_W'(OFS_PRIO_LOW) || paddr == ADDR_W'(OFS_PRIO_HIGH));
		endInstr = cycleEnd && lastCycle;
		blockPoll = cur.holdOff || retiOrRegWrite || regWrite;
		topMark = fic_top_level(cur.inProgress);
	end
	// ======================================================
	// next state
	always_comb begin
		next_cur = cur;
		next_cur.pushPc = 1'b0;
		next_cur.loadPc = 1'b0;
		next_cur.clr0 = 1'b0;
		next_cur.clr1 = 1'b0;
		next_cur.clrExt0 = 1'b0;
		next_cur.clrExt1 = 1'b0;
		next_cur.pop = 1'b0;
		// samples are overwritten, so a dropped request is forgotten
		if (state5Phase2) begin
			next_cur.samples = liveFlags;
		end
		// poll set takes this cycle's samples at cycle end, one clock after the strobe
		if (cycleEnd) begin
			next_cur.polled = cur.samples;
			// external flags were latched at this cycle's sample strobe
			next_cur.polled[SRC_EXT0] = ext0Flag;
			next_cur.polled[SRC_EXT1] = ext1Flag;
		end
		// timer2 overflow is polled in the cycle it happens
		if (state2Phase2 && timer2OverflowFlag) begin
			next_cur.polled[SRC_TMR2] = 1'b1;
		end
		// one instruction end consumes the hold-off
		if (endInstr) begin
			next_cur.holdOff = 1'b0;
		end else if (retiOrRegWrite || regWrite) begin
			next_cur.holdOff = 1'b1;
		end
		if (returnFromInterrupt && topMark[2]) begin
			next_cur.inProgress[topMark[1:0]] = 1'b0;
		end
		// plain returns have no input here: markers stay as they are
		if (returnFromInterrupt) begin
			next_cur.pop = 1'b1;
		end
		unique case (cur.call)
			CALL_IDLE: begin
				if (endInstr && grantValid && !blockPoll) begin
					next_cur.call = CALL_PUSH;
					next_cur.pushPc = 1'b1;
					next_cur.vector = fic_vector(grantSrc);
					next_cur.inProgress[grantLevel] = 1'b1;
					next_cur.clr0 = grantSrc == SRC_TMR0;
					next_cur.clr1 = grantSrc == SRC_TMR1;
					next_cur.clrExt0 = grantSrc == SRC_EXT0;
					next_cur.clrExt1 = grantSrc == SRC_EXT1;
				end
			end
			CALL_PUSH: begin
				if (cycleEnd) begin
					next_cur.call = CALL_LOAD;
				end
			end
			CALL_LOAD: begin
				if (cycleEnd) begin
					next_cur.call = CALL_IDLE;
					next_cur.loadPc = 1'b1;
				end
			end
			default: begin
				next_cur.call = CALL_IDLE;
			end
		endcase
		if (regWrite || (accessPhase && pwrite)) begin
			case (paddr)
				ADDR_W'(OFS_ENABLE): next_cur.enable = pwdata[7:0];
				ADDR_W'(OFS_PRIO_LOW): next_cur.prioLow = pwdata[6:0];
				ADDR_W'(OFS_PRIO_HIGH): next_cur.prioHigh = pwdata[6:0];
				ADDR_W'(OFS_CONTROL): next_cur.edgeMode = pwdata[1:0];
				default: begin
				end
			endcase
		end
		// read data is latched in setup, address is stable then
		if (setupPhase) begin
			case (paddr)
				ADDR_W'(OFS_ENABLE): next_cur.rdata = {24'h0, cur.enable};
				ADDR_W'(OFS_PRIO_LOW): next_cur.rdata = {25'h0, cur.prioLow};
				ADDR_W'(OFS_PRIO_HIGH): next_cur.rdata = {25'h0, cur.prioHigh};
				ADDR_W'(OFS_CONTROL): next_cur.rdata = {30'h0, cur.edgeMode};
				ADDR_W'(OFS_STATUS): next_cur.rdata = {18'h0, cur.holdOff,
					cur.call, cur.samples, cur.inProgress};
				default: next_cur.rdata = 32'h0;
			endcase
		end
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cur <= '{enable: RST_ENABLE, prioLow: RST_PRIO, prioHigh: RST_PRIO,
				edgeMode: RST_CONTROL, call: CALL_IDLE, default: '0};
		end else begin
			cur <= next_cur;
		end
	end
	assign pready = 1'b1;
	assign pslverr = accessPhase && !mapped;
	assign prdata = cur.rdata;
	assign callActive = cur.call != CALL_IDLE;
	assign pushPc = cur.pushPc;
	assign loadPc = cur.loadPc;
	assign vectorAddress = cur.vector;
	assign clearTimer0Overflow = cur.clr0;
	assign clearTimer1Overflow = cur.clr1;
	assign popTwoBytes = cur.pop;
	// ======================================================
	// checks
	logic [1:0] callEnds;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			callEnds <= 2'h0;
		end else if (cur.pushPc) begin
			callEnds <= 2'h0;
		end else if (callActive && cycleEnd) begin
			callEnds <= 2'(callEnds + 2'h1);
		end
	end
	a_call_two_cycles: assert property (@(posedge sys_clk) disable iff (!reset_n)
		loadPc |-> callEnds == 2'(CALL_CYCLES))
		else $error("vector call did not span two machine cycles");
	a_push_at_start: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(callActive) |-> pushPc && !loadPc)
		else $error("call started without a push");
	a_poll_at_end: assert property (@(posedge sys_clk) disable iff (!reset_n)
		pushPc |-> $past(cycleEnd) && $past(lastCycle))
		else $error("call started inside an instruction");
	a_hold_blocks: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(endInstr && cur.holdOff) |=> !pushPc)
		else $error("vector taken right after return or register write");
	a_global_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
		pushPc |-> $past(cur.enable[BIT_GLOBAL]))
		else $error("vector taken with global enable low");
	a_timer_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
		clearTimer0Overflow |-> pushPc && vectorAddress == 16'h000B)
		else $error("timer 0 flag cleared outside its vector");
	a_strict_preempt: assert property (@(posedge sys_clk) disable iff (!reset_n)
		pushPc |-> (cur.inProgress ^ $past(cur.inProgress))
			> $past(cur.inProgress))
		else $error("preempted by equal or lower level");
	a_return_from_interrupt_pop: assert property (@(posedge sys_clk) disable iff (!reset_n)
		returnFromInterrupt |=> popTwoBytes)
		else $error("return did not pop the program counter");
	a_vector_legal: assert property (@(posedge sys_clk) disable iff (!reset_n)
		loadPc |-> vectorAddress[2:0] == 3'h3
			&& vectorAddress <= 16'h0033)
		else $error("illegal vector address");
	a_cap_vector: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(cur.call == CALL_IDLE && endInstr && grantValid && !blockPoll
			&& grantSrc == SRC_CAPT) |=> vectorAddress == 16'h0033)
		else $error("capture array vector wrong");
endmodule : fic_top
`default_nettype wire

// ### verification/fic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module fic_core_model (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic longInstr,
	output logic state5Phase2,
	output logic state2Phase2,
	output logic cycleEnd,
	output logic lastCycle
);
	logic [2:0] phase;
	logic oddCycle;
	// ========================================
	// machine cycle of six clocks
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			phase <= 3'h0;
			oddCycle <= 1'b0;
		end else if (phase == 3'h5) begin
			phase <= 3'h0;
			oddCycle <= ~oddCycle;
		end else begin
			phase <= phase + 3'h1;
		end
	end
	assign state2Phase2 = phase == 3'h1;
	assign state5Phase2 = phase == 3'h4;
	assign cycleEnd = phase == 3'h5;
	// long instructions end only on odd cycles
	assign lastCycle = !longInstr || oddCycle;
endmodule : fic_core_model
`default_nettype wire

// ### verification/test_four_level_interrupt_controller.sv
`timescale 1ns/1ps
`default_nettype none
module test_four_level_interrupt_controller;
	import fic_pkg::*;
	logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic pready, pslverr, err, longInstr = 0, rfi = 0, holdExt0 = 0;
	logic s5, s2, cycleEnd, lastCycle, lastSeen = 0, retiOrWrite = 0;
	logic callActive, pushPc, loadPc, clr0, clr1, pop;
	logic [15:0] vectorAddress;
	logic [8:0] srcOn = 9'h000;
	int miscompares = 0, check_count = 0, lat;
	// polling order, then serial tx and timer2 external
	localparam logic [15:0] VEC [9] = '{16'h0003, 16'h000B, 16'h0013,
		16'h001B, 16'h0033, 16'h0023, 16'h002B, 16'h0023, 16'h002B};
	fic_core_model fic_core_model_i (.sys_clk(sys_clk), .reset_n(reset_n),
		.longInstr(longInstr), .state5Phase2(s5), .state2Phase2(s2),
		.cycleEnd(cycleEnd), .lastCycle(lastCycle));
	fic_top fic_top_i (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.ext_request_0_n(~(srcOn[0] | holdExt0)),
		.ext_request_1_n(~srcOn[2]), .state5Phase2(s5), .state2Phase2(s2),
		.cycleEnd(cycleEnd), .lastCycle(lastCycle),
		.retiOrRegWrite(retiOrWrite),
		.returnFromInterrupt(rfi), .timer0OverflowFlag(srcOn[1]),
		.timer1OverflowFlag(srcOn[3]), .timer2OverflowFlag(srcOn[6]),
		.timer2ExternalFlag(srcOn[8]), .serialRxFlag(srcOn[5]),
		.serialTxFlag(srcOn[7]), .captureArrayFlag(srcOn[4]),
		.callActive(callActive), .pushPc(pushPc), .loadPc(loadPc),
		.vectorAddress(vectorAddress), .clearTimer0Overflow(clr0),
		.clearTimer1Overflow(clr1), .popTwoBytes(pop));
	initial forever #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (cycleEnd) lastSeen <= lastCycle;
	// ========================================
	// compare and bus tasks
	task check_word(input string name, input logic [31:0] e, got);
		check_count++;
		if (got !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, e, got);
		end
	endtask : check_word
	task check_bit(input string name, input logic e, got);
		check_word(name, {31'h0, e}, {31'h0, got});
	endtask : check_bit
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		// pready is tied high, so this wait ends after one clock
		do @(posedge sys_clk); while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [7:0] a, input logic [31:0] e, input logic eErr);
		apb(1'b0, a, 32'h0);
		check_word("read data", e, rdata);
		check_bit("slave error", eErr, err);
	endtask : rd
	// ========================================
	// call handling
	task take_call(input int idx);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pushPc !== 1'b1 && n < 200);
		lat = n;
		check_bit("call taken", 1'b1, pushPc);
		check_word("vector", {16'h0, VEC[idx]}, {16'h0, vectorAddress});
		check_bit("clear timer0", idx == 1, clr0);
		check_bit("clear timer1", idx == 3, clr1);
		check_bit("last cycle", 1'b1, lastSeen);
		srcOn[idx] <= 1'b0;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (loadPc !== 1'b1 && n < 200);
		lat += n;
		check_bit("call length", 1'b1, n == 12);
		check_bit("call ended", 1'b0, callActive);
	endtask : take_call
	task return_from_interrupt();
		@(posedge sys_clk);
		rfi <= 1'b1;
		@(posedge sys_clk);
		rfi <= 1'b0;
		@(posedge sys_clk);
		check_bit("pop", 1'b1, pop);
	endtask : return_from_interrupt
	task no_call(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(posedge sys_clk);
			seen = seen | pushPc;
		end
		check_bit("no call", 1'b0, seen);
	endtask : no_call
	task single(input int idx);
		do @(posedge sys_clk); while (cycleEnd !== 1'b1);
		srcOn[idx] <= 1'b1;
		take_call(idx);
		check_bit("latency", 1'b1, lat > 18 && lat < 54);
		return_from_interrupt();
	endtask : single
	// ========================================
	// scenarios
	task t_regs();
		rd(OFS_ENABLE, 32'h0, 1'b0);
		rd(OFS_PRIO_LOW, 32'h0, 1'b0);
		rd(OFS_CONTROL, 32'h0, 1'b0);
		rd(8'h20, 32'h0, 1'b1);
		apb(1'b1, OFS_PRIO_HIGH, 32'h000000FF);
		rd(OFS_PRIO_HIGH, 32'h0000007F, 1'b0);
		apb(1'b1, OFS_PRIO_HIGH, 32'h0);
	endtask : t_regs
	task t_order();
		srcOn <= 9'h07F;
		for (int i = 0; i < 7; i++) begin
			take_call(i);
			return_from_interrupt();
		end
	endtask : t_order
	task t_prio();
		apb(1'b1, OFS_PRIO_HIGH, 32'h00000020);
		srcOn <= 9'h041;
		take_call(6);
		return_from_interrupt();
		take_call(0);
		return_from_interrupt();
		apb(1'b1, OFS_PRIO_HIGH, 32'h0);
	endtask : t_prio
	task t_preempt();
		apb(1'b1, OFS_PRIO_LOW, 32'h00000006);
		apb(1'b1, OFS_PRIO_HIGH, 32'h00000008);
		srcOn[1] <= 1'b1;
		take_call(1);
		srcOn[2:0] <= 3'h5;
		no_call(40);
		srcOn[2:0] <= 3'h0;
		srcOn[3] <= 1'b1;
		take_call(3);
		rd(OFS_STATUS, 32'h00000006, 1'b0);
		return_from_interrupt();
		rd(OFS_STATUS, 32'h00000002, 1'b0);
		return_from_interrupt();
		no_call(40);
		apb(1'b1, OFS_PRIO_LOW, 32'h0);
		apb(1'b1, OFS_PRIO_HIGH, 32'h0);
	endtask : t_preempt
	task t_enable();
		apb(1'b1, OFS_ENABLE, 32'h0000007F);
		srcOn[0] <= 1'b1;
		no_call(40);
		srcOn[0] <= 1'b0;
		no_call(12);
		apb(1'b1, OFS_ENABLE, 32'h000000FF);
		no_call(40);
		apb(1'b1, OFS_ENABLE, 32'h00000080);
		srcOn[1] <= 1'b1;
		no_call(40);
		srcOn[1] <= 1'b0;
		no_call(12);
		apb(1'b1, OFS_ENABLE, 32'h000000FF);
	endtask : t_enable
	task t_edge();
		apb(1'b1, OFS_CONTROL, 32'h00000001);
		holdExt0 <= 1'b1;
		take_call(0);
		return_from_interrupt();
		no_call(60);
		holdExt0 <= 1'b0;
		apb(1'b1, OFS_CONTROL, 32'h0);
	endtask : t_edge
	task t_hold();
		do @(posedge sys_clk); while (cycleEnd !== 1'b1);
		srcOn[1] <= 1'b1;
		// two instructions flagged: the poll ending the second is blocked
		retiOrWrite <= 1'b1;
		no_call(12);
		retiOrWrite <= 1'b0;
		no_call(1);
		take_call(1);
		return_from_interrupt();
	endtask : t_hold
	task end_of_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test
	initial begin
		#1000000;
		miscompares++;
		end_of_test();
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_regs();
		apb(1'b1, OFS_ENABLE, 32'h000000FF);
		for (int i = 0; i < 9; i++) single(i);
		t_order();
		t_prio();
		t_preempt();
		t_enable();
		t_edge();
		t_hold();
		longInstr <= 1'b1;
		single(3);
		end_of_test();
	end
endmodule : test_four_level_interrupt_controller
`default_nettype wire
